// *** verilog/lcd_display_mode_control.sv ***
/*
 * Command interpreter of a dot-matrix LCD driver: display on/standby, page and
 * column addressing, bulk clears, icon line multiplex, icon mode, contrast and
 * the frame divider, with the display RAM held in flip-flops.
 * Assumes a host on an 8-bit parallel port whose pins are asynchronous to
 * i_clock, and a display oscillator far slower than i_clock.
 */
`include "lcd_cfg.svh"

module lcd_display_mode_control (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_bus_enable,
	input wire logic i_bus_dc,
	input wire logic [7:0] i_bus_data,
	input wire logic i_osc,
	input wire logic [2:0] i_scan_page,
	input wire logic [6:0] i_scan_col,
	output logic [7:0] o_scan_data,
	output logic o_drivers_enable,
	output logic o_outputs_grounded,
	output logic o_bias_enable,
	output logic o_osc_enable,
	output logic o_clock_slow,
	output logic [3:0] o_static_icon,
	output logic [2:0] o_page,
	output logic [6:0] o_column,
	output lcd_pkg::mux_e o_mux,
	output logic o_icon_mode,
	output logic o_graphic_rows_enable,
	output logic o_icon_row_enable,
	output logic [1:0] o_icon_contrast,
	output logic o_frame_tick
);

	lcd_pkg::pins_s pins_raw;
	lcd_pkg::pins_s sync1;
	lcd_pkg::pins_s sync2;
	lcd_pkg::pins_s sync3;
	lcd_pkg::pins_s pins;
	logic enable_prev;
	logic osc_prev;
	logic access;
	logic cmd_wr;
	logic data_wr;
	logic [7:0] cmd;
	logic osc_rise;
	logic display_on;
	lcd_pkg::clear_e clear_state;
	logic fire_gfx;
	logic fire_icon;
	logic store_wr;
	logic [9:0] wr_index;
	logic [9:0] rd_index;
	logic [9:0] div_count;
	logic [9:0] div_last;
	logic [7:0] ram [`RAM_BYTES];

	assign pins_raw = '{enable: i_bus_enable, dc: i_bus_dc, data: i_bus_data, osc: i_osc};

	// Only the second stage reads the first one.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else if (i_clk_en) begin
			sync1 <= pins_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// A bit changes only once stages two and three agree, which rejects glitches.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pins <= '0;
		end else if (i_clk_en) begin
			pins <= (sync2 & sync3) | (pins & (sync2 | sync3));
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_prev <= 1'b0;
			osc_prev <= 1'b0;
		end else if (i_clk_en) begin
			enable_prev <= pins.enable;
			osc_prev <= pins.osc;
		end
	end

	// The access is taken as the enable falls, when data is settled and held.
	assign access = i_clk_en && enable_prev && !pins.enable;
	assign cmd_wr = access && !pins.dc;
	assign data_wr = access && pins.dc;
	assign cmd = pins.data;
	assign osc_rise = i_clk_en && pins.osc && !osc_prev;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			display_on <= 1'b0;
		end else if (cmd_wr && cmd == `CMD_DISPLAY_ON) begin
			display_on <= 1'b1;
		end else if (cmd_wr && cmd == `CMD_DISPLAY_OFF) begin
			display_on <= 1'b0;
		end
	end

	assign o_drivers_enable = display_on;
	assign o_outputs_grounded = !display_on;
	assign o_bias_enable = display_on;

	// Oscillator and static icons have their own commands only.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_osc_enable <= 1'b0;
			o_clock_slow <= 1'b0;
		end else if (cmd_wr) begin
			if (cmd == `CMD_OSC_ON) begin
				o_osc_enable <= 1'b1;
			end else if (cmd == `CMD_OSC_OFF) begin
				o_osc_enable <= 1'b0;
			end else if (cmd == `CMD_CLK_SLOW) begin
				o_clock_slow <= 1'b1;
			end else if (cmd == `CMD_CLK_NORMAL) begin
				o_clock_slow <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_static_icon <= `RST_STATIC_ICON;
		end else if (cmd_wr && cmd[7:4] == `CMD_STATIC_BASE) begin
			o_static_icon <= cmd[3:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_icon_contrast <= `RST_ICON_CONTRAST;
		end else if (cmd_wr && cmd[7:2] == `CMD_CONTRAST_BASE) begin
			o_icon_contrast <= cmd[1:0];
		end
	end

	// Multiplex and icon mode; 1/16 is left alone by the icon-line command.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mux <= lcd_pkg::MUX_32;
			o_icon_mode <= 1'b0;
		end else if (cmd_wr) begin
			if (cmd == `CMD_MUX_16) begin
				o_mux <= lcd_pkg::MUX_16;
			end else if (cmd == `CMD_MUX_32) begin
				o_mux <= lcd_pkg::MUX_32;
			end else if (cmd == `CMD_ICON_LINE) begin
				o_icon_mode <= 1'b0;
				if (o_mux == lcd_pkg::MUX_32) begin
					o_mux <= lcd_pkg::MUX_33;
				end
			end else if (cmd == `CMD_ICON_MODE) begin
				o_icon_mode <= 1'b1;
			end
		end
	end

	assign o_graphic_rows_enable = display_on && !o_icon_mode;
	assign o_icon_row_enable = display_on && (o_icon_mode || o_mux == lcd_pkg::MUX_33);

	// Page codes beyond the icon page are ignored, so the pointer stays legal.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_page <= 3'h0;
		end else if (cmd_wr && cmd[7:3] == `CMD_PAGE_BASE && cmd[2:0] <= `ICON_PAGE) begin
			o_page <= cmd[2:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_column <= 7'h00;
		end else if (cmd_wr && cmd[7:4] == `CMD_COL_LOW) begin
			o_column <= {o_column[6:4], cmd[3:0]};
		end else if (cmd_wr && cmd[7:4] == `CMD_COL_HIGH) begin
			o_column <= {cmd[2:0], o_column[3:0]};
		end else if (store_wr) begin
			o_column <= (o_column >= `LAST_COL) ? 7'h00 : o_column + 7'h01;
		end
	end

	// A clear command arms; the next data write fires it instead of storing.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clear_state <= lcd_pkg::CLR_IDLE;
		end else if (cmd_wr && cmd == `CMD_CLEAR_GFX) begin
			clear_state <= lcd_pkg::CLR_GFX;
		end else if (cmd_wr && cmd == `CMD_CLEAR_ICON) begin
			clear_state <= lcd_pkg::CLR_ICON;
		end else if (data_wr) begin
			clear_state <= lcd_pkg::CLR_IDLE;
		end
	end

	assign fire_gfx = data_wr && clear_state == lcd_pkg::CLR_GFX;
	assign fire_icon = data_wr && clear_state == lcd_pkg::CLR_ICON;
	assign store_wr = data_wr && clear_state == lcd_pkg::CLR_IDLE;
	assign wr_index = 10'(o_page * 10'd120) + {3'h0, o_column};

	// Every byte clears in one cycle, far inside the host's access spacing.
	genvar e;
	generate
		for (e = 0; e < `RAM_BYTES; e++) begin : g_byte
			localparam bit IS_ICON = (e >= `GFX_BYTES);
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					ram[e] <= 8'h00;
				end else if (!IS_ICON && fire_gfx) begin
					ram[e] <= 8'h00;
				end else if (IS_ICON && fire_icon) begin
					ram[e] <= 8'h00;
				end else if (store_wr && wr_index == 10'(e)) begin
					ram[e] <= cmd;
				end
			end
		end
	endgenerate

	// The icon row is addressed directly, outside any remap of graphic rows.
	assign rd_index = 10'(i_scan_page * 10'd120) + {3'h0, i_scan_col};

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_scan_data <= 8'h00;
		end else if (i_clk_en) begin
			if (!display_on || rd_index >= 10'(`RAM_BYTES) || i_scan_col > `LAST_COL) begin
				o_scan_data <= 8'h00;
			end else if (o_icon_mode && i_scan_page != `ICON_PAGE) begin
				o_scan_data <= 8'h00;
			end else begin
				o_scan_data <= ram[rd_index];
			end
		end
	end

	// The divider runs only while the oscillator is enabled.
	assign div_last = o_clock_slow ? 10'(`FRAME_DIV_SLOW - 1) : 10'(`FRAME_DIV_NORMAL - 1);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_count <= 10'h000;
			o_frame_tick <= 1'b0;
		end else if (i_clk_en) begin
			o_frame_tick <= 1'b0;
			if (!o_osc_enable) begin
				div_count <= 10'h000;
			end else if (osc_rise) begin
				if (div_count >= div_last) begin
					div_count <= 10'h000;
					o_frame_tick <= 1'b1;
				end else begin
					div_count <= div_count + 10'h001;
				end
			end
		end
	end

	logic gfx_any;
	always_comb begin
		gfx_any = 1'b0;
		for (int i = 0; i < `GFX_BYTES; i++) begin
			gfx_any = gfx_any | (|ram[i]);
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	frame_slow_a: assert property (osc_rise && o_osc_enable && o_clock_slow &&
		div_count == 10'h23F |=> o_frame_tick) else $error("slow frame tick missed");
	frame_normal_a: assert property (osc_rise && o_osc_enable && !o_clock_slow &&
		div_count == 10'h2FF |=> o_frame_tick) else $error("normal frame tick missed");
	display_on_a: assert property (cmd_wr && cmd == `CMD_DISPLAY_ON |=>
		o_drivers_enable && o_bias_enable && !o_outputs_grounded) else $error("display on failed");
	display_icons_a: assert property (cmd_wr &&
		(cmd == `CMD_DISPLAY_ON || cmd == `CMD_DISPLAY_OFF) |=> $stable(o_static_icon) &&
		$stable(o_osc_enable)) else $error("display command touched icons or oscillator");
	display_off_a: assert property (cmd_wr && cmd == `CMD_DISPLAY_OFF |=>
		!o_bias_enable && o_outputs_grounded ##1 o_scan_data == 8'h00)
		else $error("display off not grounded");
	page_set_a: assert property (cmd_wr && cmd[7:3] == `CMD_PAGE_BASE &&
		cmd[2:0] <= `ICON_PAGE |=> o_page == $past(cmd[2:0])) else $error("page not set");
	gfx_clear_a: assert property (fire_gfx |=> !gfx_any && $stable(ram[`GFX_BYTES]))
		else $error("graphic clear wrong");
	icon_clear_a: assert property (fire_icon |=>
		ram[`GFX_BYTES] == 8'h00 && ram[`RAM_BYTES - 1] == 8'h00) else $error("icon clear wrong");
	icon_line_a: assert property (cmd_wr && cmd == `CMD_ICON_LINE &&
		o_mux == lcd_pkg::MUX_32 |=> o_mux == lcd_pkg::MUX_33 && !o_icon_mode)
		else $error("icon line mux wrong");
	icon_exit_a: assert property (cmd_wr && cmd == `CMD_ICON_LINE |=> !o_icon_mode)
		else $error("icon mode kept");
	icon_rows_a: assert property (o_icon_mode && i_clk_en && i_scan_page != `ICON_PAGE |=>
		o_scan_data == 8'h00) else $error("graphic page shown in icon mode");
	dummy_write_a: assert property (fire_gfx || fire_icon |=> $stable(o_column) &&
		clear_state == lcd_pkg::CLR_IDLE) else $error("dummy write stored");

	clear_gfx_c: cover property (cmd_wr && cmd == `CMD_CLEAR_GFX ##[1:200] fire_gfx);
	icon_mode_c: cover property (cmd_wr && cmd == `CMD_ICON_MODE ##[1:200]
		cmd_wr && cmd == `CMD_ICON_LINE);
	frame_c: cover property (o_frame_tick && o_clock_slow);

endmodule : lcd_display_mode_control

// *** verilog/lcd_cfg.svh ***
/*
 * Constants of the LCD mode control block: command codes, reset values, RAM
 * geometry and frame divider counts.
 * Assumes it is included by its bare name wherever the constants are needed.
 */
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

`define NUM_PAGES 5
`define NUM_COLS 120
`define ICON_PAGE 3'h4
`define GFX_BYTES 480
`define RAM_BYTES 600
`define LAST_COL 7'h77

`define FRAME_DIV_SLOW 576
`define FRAME_DIV_NORMAL 768

`define CMD_DISPLAY_OFF 8'hAE
`define CMD_DISPLAY_ON 8'hAF
`define CMD_PAGE_BASE 5'h16
`define CMD_COL_LOW 4'h0
`define CMD_COL_HIGH 4'h1
`define CMD_CLEAR_GFX 8'hE0
`define CMD_CLEAR_ICON 8'hE1
`define CMD_MUX_16 8'hAA
`define CMD_MUX_32 8'hAB
`define CMD_ICON_LINE 8'hA9
`define CMD_ICON_MODE 8'hA3
`define CMD_CONTRAST_BASE 6'h24
`define CMD_OSC_OFF 8'hD2
`define CMD_OSC_ON 8'hD3
`define CMD_CLK_SLOW 8'hD4
`define CMD_CLK_NORMAL 8'hD5
`define CMD_STATIC_BASE 4'hC

`define RST_ICON_CONTRAST 2'h0
`define RST_STATIC_ICON 4'h0

`endif

// *** verilog/lcd_pkg.sv ***
/*
 * Types shared by the LCD mode control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcd_pkg;

	typedef enum logic [1:0] {
		MUX_16 = 2'h0,
		MUX_32 = 2'h1,
		MUX_33 = 2'h3
	} mux_e;

	typedef enum logic [1:0] {
		CLR_IDLE = 2'h0,
		CLR_GFX = 2'h1,
		CLR_ICON = 2'h3
	} clear_e;

	typedef struct packed {
		logic enable;
		logic dc;
		logic [7:0] data;
		logic osc;
	} pins_s;

endpackage : lcd_pkg

// *** bench/lcd_host_model.sv ***
/*
 * Host model: writes bytes on the parallel port and runs the display oscillator.
 * Assumes the bench clock on i_clock and a bench that calls send.
 */
`include "lcd_cfg.svh"

module lcd_host_model (
	input wire logic i_clock,
	output logic o_bus_enable,
	output logic o_bus_dc,
	output logic [7:0] o_bus_data,
	output logic o_osc
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_bus_enable = 1'b1;
		o_bus_dc = 1'b0;
		o_bus_data = 8'h00;
		o_osc = 1'b0;
	end

	// The oscillator runs free, eight bench clocks a period, so frame gaps are exact.
	always begin
		repeat (4) @(posedge i_clock);
		#2 o_osc = ~o_osc;
	end

	// Six clocks of setup and hold outlast the pin filter on both sides.
	task automatic send(input logic dc, input logic [7:0] value);
		@(posedge i_clock);
		#2;
		o_bus_dc = dc;
		o_bus_data = value;
		repeat (6) @(posedge i_clock);
		#2 o_bus_enable = 1'b0;
		repeat (8) @(posedge i_clock);
		#2 o_bus_enable = 1'b1;
		repeat (6) @(posedge i_clock);
		#2;
		o_bus_dc = ~dc;
		o_bus_data = ~value;
	endtask : send

	// For an icon clear the icon page is selected first, and every clear is followed by a dummy write.
	task automatic clear(input logic icon);
		if (icon) begin
			send(1'b0, {`CMD_PAGE_BASE, `ICON_PAGE});
		end
		send(1'b0, icon ? `CMD_CLEAR_ICON : `CMD_CLEAR_GFX);
		send(1'b1, 8'hFF);
	endtask : clear
endmodule : lcd_host_model

// *** bench/lcd_display_mode_control_tb.sv ***
/*
 * Self-checking bench of the LCD mode control block with a host model.
 * Assumes the design files and lcd_cfg.svh are on the include path.
 */
`include "lcd_cfg.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module lcd_display_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic bus_enable, bus_dc, osc;
	logic [7:0] bus_data, scan_data;
	logic [2:0] scan_page = 3'h0, page;
	logic [6:0] scan_col = 7'h00, column;
	logic drivers, grounded, bias, osc_en, slow, icon_mode, gfx_rows, icon_row, tick;
	logic [3:0] static_icon;
	logic [1:0] contrast;
	lcd_pkg::mux_e mux;
	int error_cnt = 0;
	int compares = 0;
	int n;

	always #10 clock = ~clock;

	lcd_host_model u_lcd_host_model (.i_clock(clock), .o_bus_enable(bus_enable),
		.o_bus_dc(bus_dc), .o_bus_data(bus_data), .o_osc(osc));

	lcd_display_mode_control u_lcd_display_mode_control (.i_clock(clock), .i_rst_n(rst_n),
		.i_clk_en(clk_en), .i_bus_enable(bus_enable), .i_bus_dc(bus_dc),
		.i_bus_data(bus_data), .i_osc(osc), .i_scan_page(scan_page), .i_scan_col(scan_col),
		.o_scan_data(scan_data), .o_drivers_enable(drivers), .o_outputs_grounded(grounded),
		.o_bias_enable(bias), .o_osc_enable(osc_en), .o_clock_slow(slow),
		.o_static_icon(static_icon), .o_page(page), .o_column(column), .o_mux(mux),
		.o_icon_mode(icon_mode), .o_graphic_rows_enable(gfx_rows),
		.o_icon_row_enable(icon_row), .o_icon_contrast(contrast), .o_frame_tick(tick));

	task automatic cmd(input logic [7:0] value);
		u_lcd_host_model.send(1'b0, value);
	endtask : cmd

	task automatic scan(input logic [2:0] p, input logic [6:0] c);
		@(posedge clock);
		#2;
		scan_page = p;
		scan_col = c;
		repeat (2) @(posedge clock);
		#2;
	endtask : scan

	task automatic wait_tick();
		int i;
		for (i = 0; i < 8000; i++) begin
			@(posedge clock);
			#1;
			if (tick === 1'b1) begin
				n = i + 1;
				return;
			end
		end
		error_cnt++;
	endtask : wait_tick

	task automatic t_reset();
		`CHK(drivers, 1'b0)
		`CHK(grounded, 1'b1)
		`CHK(bias, 1'b0)
		`CHK(mux, lcd_pkg::MUX_32)
		$display("test reset done");
	endtask : t_reset

	task automatic t_display();
		cmd({`CMD_STATIC_BASE, 4'h9});
		cmd(`CMD_OSC_ON);
		cmd(`CMD_DISPLAY_ON);
		`CHK(drivers, 1'b1)
		`CHK(grounded, 1'b0)
		`CHK(bias, 1'b1)
		`CHK(static_icon, 4'h9)
		cmd(`CMD_DISPLAY_OFF);
		`CHK(grounded, 1'b1)
		`CHK(bias, 1'b0)
		`CHK(osc_en, 1'b1)
		`CHK(static_icon, 4'h9)
		cmd({`CMD_COL_LOW, 4'h3});
		cmd({`CMD_COL_HIGH, 4'h0});
		u_lcd_host_model.send(1'b1, 8'h11);
		`CHK(column, 7'h04)
		scan(3'h0, 7'h03);
		`CHK(scan_data, 8'h00)
		cmd({`CMD_STATIC_BASE, 4'h6});
		`CHK(osc_en, 1'b1)
		cmd(`CMD_DISPLAY_ON);
		scan(3'h0, 7'h03);
		`CHK(scan_data, 8'h11)
		$display("test display done");
	endtask : t_display

	task automatic t_ram();
		cmd({`CMD_PAGE_BASE, 3'h2});
		`CHK(page, 3'h2)
		cmd({`CMD_COL_LOW, 4'h0});
		u_lcd_host_model.send(1'b1, 8'hA5);
		cmd({`CMD_PAGE_BASE, `ICON_PAGE});
		cmd({`CMD_COL_LOW, 4'h0});
		u_lcd_host_model.send(1'b1, 8'h3C);
		scan(3'h2, 7'h00);
		`CHK(scan_data, 8'hA5)
		u_lcd_host_model.clear(1'b0);
		`CHK(column, 7'h01)
		scan(3'h2, 7'h00);
		`CHK(scan_data, 8'h00)
		scan(3'h4, 7'h00);
		`CHK(scan_data, 8'h3C)
		scan(3'h4, 7'h01);
		`CHK(scan_data, 8'h00)
		u_lcd_host_model.clear(1'b1);
		scan(3'h4, 7'h00);
		`CHK(scan_data, 8'h00)
		$display("test ram done");
	endtask : t_ram

	task automatic t_mux();
		int l;
		cmd(`CMD_MUX_16);
		`CHK(mux, lcd_pkg::MUX_16)
		cmd(`CMD_ICON_LINE);
		`CHK(mux, lcd_pkg::MUX_16)
		`CHK(icon_row, 1'b0)
		cmd(`CMD_MUX_32);
		`CHK(mux, lcd_pkg::MUX_32)
		cmd({`CMD_PAGE_BASE, 3'h1});
		cmd({`CMD_COL_LOW, 4'h0});
		u_lcd_host_model.send(1'b1, 8'h5A);
		cmd(`CMD_ICON_LINE);
		`CHK(mux, lcd_pkg::MUX_33)
		cmd(`CMD_ICON_MODE);
		`CHK(icon_mode, 1'b1)
		`CHK(gfx_rows, 1'b0)
		`CHK(icon_row, 1'b1)
		scan(3'h1, 7'h00);
		`CHK(scan_data, 8'h00)
		for (l = 0; l < 4; l++) begin
			cmd({`CMD_CONTRAST_BASE, l[1:0]});
			`CHK(contrast, l[1:0])
		end
		cmd(`CMD_ICON_LINE);
		`CHK(icon_mode, 1'b0)
		`CHK(gfx_rows, 1'b1)
		scan(3'h1, 7'h00);
		`CHK(scan_data, 8'h5A)
		$display("test mux done");
	endtask : t_mux

	// The first gap after a rate change may be partial, so it is skipped.
	task automatic t_frame(input logic [7:0] rate);
		cmd(rate);
		`CHK(slow, rate == `CMD_CLK_SLOW)
		wait_tick();
		wait_tick();
		wait_tick();
	endtask : t_frame

	// Freezing for whole oscillator periods delays the next tick by exactly the frozen span.
	// The count n starts 65 edges after the previous tick, hence the offset.
	task automatic t_hold();
		int hits;
		@(posedge clock);
		#2 clk_en = 1'b0;
		repeat (64) @(posedge clock);
		#2 clk_en = 1'b1;
		wait_tick();
		`CHK(n + 65, `FRAME_DIV_NORMAL * 8 + 64)
		cmd(`CMD_OSC_OFF);
		`CHK(osc_en, 1'b0)
		hits = 0;
		repeat (6400) begin
			@(posedge clock);
			#1;
			if (tick === 1'b1) begin
				hits++;
			end
		end
		`CHK(hits, 0)
		$display("test hold done");
	endtask : t_hold

	task automatic finish_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#1600000;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge clock);
		#2 rst_n = 1'b1;
		t_reset();
		t_display();
		t_ram();
		t_mux();
		t_frame(`CMD_CLK_SLOW);
		`CHK(n, `FRAME_DIV_SLOW * 8)
		t_frame(`CMD_CLK_NORMAL);
		`CHK(n, `FRAME_DIV_NORMAL * 8)
		$display("test frame done");
		t_hold();
		finish_test();
	end
endmodule : lcd_display_mode_control_tb
